// *** logic/elpo_consts.vh ***
/*
 * Constants for the legacy-support and port-override configuration registers.
 * Assumes byte-addressed configuration space with dword-aligned accesses.
 */
// Behaviour
// - Port owner bit never mirrors override register
// - Override register kept in suspend power domain
// - Override bit hands port to companion controller
// - Overridden port always reports disconnected
// - Override bits 5:1 read/write, rest reserved
// - Capability ID reads 01h
// - Next capability pointer reads 00h
// - Bit 24 OS ownership semaphore, read/write
// - Bit 16 firmware ownership semaphore, read/write
// - Capability bits 31:25, 23:17 read zero
// - Bit 30 set on command register write
// - Bit 29 set on OS semaphore change
// - Status bits 28:22 read zero
// - Shadow of async-advance status, read-only
// - Shadow of host system error, read-only
// - Shadow of frame list rollover, read-only
// - Shadow of port change detect, read-only
// - Shadow of transfer error status, read-only
`ifndef ELPO_CONSTS_VH
`define ELPO_CONSTS_VH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define ELPO_OFS_OVERRIDE 8'h64
`define ELPO_OFS_LEG_CAP 8'h68
`define ELPO_OFS_LEG_CS 8'h6C
`define ELPO_OFS_COMMAND 8'h04
`define ELPO_OFS_MEM_BAR 8'h10

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ELPO_OVR_MASK 16'h003E
`define ELPO_OVR_RESET 16'h0000
`define ELPO_CAP_ID 8'h01
`define ELPO_CAP_NEXT 8'h00
`define ELPO_CAP_OS_BIT 24
`define ELPO_CAP_FW_BIT 16
`define ELPO_CS_BAR_BIT 31
`define ELPO_CS_CMD_BIT 30
`define ELPO_CS_OSCHG_BIT 29
`define ELPO_CS_ASYNC_BIT 21
`define ELPO_CS_HSE_BIT 20
`define ELPO_CS_FLR_BIT 19
`define ELPO_CS_PCD_BIT 18
`define ELPO_CS_ERR_BIT 17
`define ELPO_NUM_PORTS 6

`endif

// *** logic/elpo_port_route.v ***
/*
 * Per-port routing: picks companion ownership and masks connect status.
 * Assumes all inputs are on core_clk from the same domain.
 */
module elpo_port_route #(
	parameter NUM_PORTS = 6
) (
	input wire [NUM_PORTS-1:0] override_bits,
	input wire [NUM_PORTS-1:0] routing_to_companion,
	input wire [NUM_PORTS-1:0] enh_connect_raw,
	output wire [NUM_PORTS-1:0] companion_owns_port,
	output wire [NUM_PORTS-1:0] enh_connect_status
);
	// ----------------------------------------
	// Routing
	// ----------------------------------------
	// Override wins over the normal decision
	assign companion_owns_port = override_bits | routing_to_companion;
	assign enh_connect_status = enh_connect_raw & ~override_bits;
endmodule // elpo_port_route

// *** logic/elpo_regs.v ***
/*
 * Legacy-support capability, control/status and companion port override
 * registers reached by configuration accesses.
 * Assumes a one-cycle write/read strobe on core_clk and shadow inputs
 * from the operational status register on the same clock.
 */
`include "elpo_consts.vh"
module elpo_regs #(
	parameter NUM_PORTS = `ELPO_NUM_PORTS
) (
	input wire core_clk,
	input wire rst,
	input wire clk_en,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	output reg [31:0] cfg_rdata,
	input wire sts_async_advance,
	input wire sts_host_sys_err,
	input wire sts_frame_rollover,
	input wire sts_port_change,
	input wire transfer_error_irq_status,
	input wire [NUM_PORTS-1:0] routing_to_companion,
	input wire [NUM_PORTS-1:0] enh_connect_raw,
	output wire [NUM_PORTS-1:0] companion_owns_port,
	output wire [NUM_PORTS-1:0] enh_connect_status,
	output wire os_owned,
	output wire fw_owned
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	// Reset here stands for suspend-well reset only; core power loss keeps it
	reg [15:0] override_reg;
	reg os_sem_reg;
	reg fw_sem_reg;
	reg smi_bar_reg;
	reg smi_cmd_reg;
	reg smi_oschg_reg;
	reg [31:0] cap_word;
	reg [31:0] cs_word;

	wire wr_ovr = cfg_wr && cfg_addr == `ELPO_OFS_OVERRIDE;
	wire wr_cap = cfg_wr && cfg_addr == `ELPO_OFS_LEG_CAP;
	wire wr_cs = cfg_wr && cfg_addr == `ELPO_OFS_LEG_CS;
	wire wr_cmd = cfg_wr && cfg_addr == `ELPO_OFS_COMMAND && (cfg_be[1] || cfg_be[0]);
	wire wr_bar = cfg_wr && cfg_addr == `ELPO_OFS_MEM_BAR && cfg_be != 4'h0;
	wire os_new = (wr_cap && cfg_be[3]) ? cfg_wdata[`ELPO_CAP_OS_BIT] : os_sem_reg;

	// Write-one-to-clear helper; a set in the same cycle wins
	function w1c;
		input cur;
		input set;
		input clr;
		begin
			w1c = set | (cur & ~clr);
		end
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Firmware is trusted to write override only before configuration
	// and never to port 0; hardware drops the port 0 bit but does not police timing.
	always @(posedge core_clk) begin
		if (rst) begin
			override_reg <= `ELPO_OVR_RESET;
			os_sem_reg <= 1'b0;
			fw_sem_reg <= 1'b0;
			smi_bar_reg <= 1'b0;
			smi_cmd_reg <= 1'b0;
			smi_oschg_reg <= 1'b0;
		end else if (clk_en) begin
			if (wr_ovr && cfg_be[0])
				override_reg <= {8'h00, cfg_wdata[7:0]} & `ELPO_OVR_MASK;
			if (wr_cap && cfg_be[2])
				fw_sem_reg <= cfg_wdata[`ELPO_CAP_FW_BIT];
			os_sem_reg <= os_new;
			smi_bar_reg <= w1c(smi_bar_reg, wr_bar,
				wr_cs && cfg_be[3] && cfg_wdata[`ELPO_CS_BAR_BIT]);
			smi_cmd_reg <= w1c(smi_cmd_reg, wr_cmd,
				wr_cs && cfg_be[3] && cfg_wdata[`ELPO_CS_CMD_BIT]);
			smi_oschg_reg <= w1c(smi_oschg_reg, os_new != os_sem_reg,
				wr_cs && cfg_be[3] && cfg_wdata[`ELPO_CS_OSCHG_BIT]);
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always @* begin
		cap_word = 32'h00000000;
		cap_word[7:0] = `ELPO_CAP_ID;
		cap_word[15:8] = `ELPO_CAP_NEXT;
		cap_word[`ELPO_CAP_FW_BIT] = fw_sem_reg;
		cap_word[`ELPO_CAP_OS_BIT] = os_sem_reg;
		cs_word = 32'h00000000;
		cs_word[`ELPO_CS_BAR_BIT] = smi_bar_reg;
		cs_word[`ELPO_CS_CMD_BIT] = smi_cmd_reg;
		cs_word[`ELPO_CS_OSCHG_BIT] = smi_oschg_reg;
		// Shadows follow the source; clearing is done at the source
		cs_word[`ELPO_CS_ASYNC_BIT] = sts_async_advance;
		cs_word[`ELPO_CS_HSE_BIT] = sts_host_sys_err;
		cs_word[`ELPO_CS_FLR_BIT] = sts_frame_rollover;
		cs_word[`ELPO_CS_PCD_BIT] = sts_port_change;
		cs_word[`ELPO_CS_ERR_BIT] = transfer_error_irq_status;
	end

	always @(posedge core_clk) begin
		if (rst) begin
			cfg_rdata <= 32'h00000000;
		end else if (clk_en && cfg_rd) begin
			case (cfg_addr)
				`ELPO_OFS_OVERRIDE: cfg_rdata <= {16'h0000, override_reg};
				`ELPO_OFS_LEG_CAP: cfg_rdata <= cap_word;
				`ELPO_OFS_LEG_CS: cfg_rdata <= cs_word;
				default: cfg_rdata <= 32'h00000000;
			endcase
		end
	end

	assign os_owned = os_sem_reg && !fw_sem_reg;
	assign fw_owned = fw_sem_reg;

	// ----------------------------------------
	// Port routing
	// ----------------------------------------
	// Operational port-owner bits are not driven from here.
	elpo_port_route #(
		.NUM_PORTS(NUM_PORTS)
	) u_route (
		.override_bits({override_reg[NUM_PORTS-1:1], 1'b0}),
		.routing_to_companion(routing_to_companion),
		.enh_connect_raw(enh_connect_raw),
		.companion_owns_port(companion_owns_port),
		.enh_connect_status(enh_connect_status)
	);
endmodule // elpo_regs

// *** tb/elpo_regs_monitor.sv ***
/* Port checker for elpo_regs.
   Assumes one clock, sync reset, accesses taken only with clk_en high. */
module elpo_regs_monitor #(
	parameter NUM_PORTS = 6
) (
	input wire core_clk,
	input wire rst,
	input wire clk_en,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	input wire [31:0] cfg_rdata,
	input wire [NUM_PORTS-1:0] routing_to_companion,
	input wire [NUM_PORTS-1:0] enh_connect_raw,
	input wire [NUM_PORTS-1:0] companion_owns_port,
	input wire [NUM_PORTS-1:0] enh_connect_status,
	input wire os_owned,
	input wire fw_owned
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_route; (routing_to_companion & ~companion_owns_port) == '0; endproperty
	a_route: assert property (p_route) else $error("route lost");
	property p_disc; ((companion_owns_port & ~routing_to_companion) & enh_connect_status) == '0;
	endproperty
	a_disc: assert property (p_disc) else $error("override port connected");
	property p_raw; (enh_connect_status & ~enh_connect_raw) == '0; endproperty
	a_raw: assert property (p_raw) else $error("phantom connect");
	// Port 0 carries debug, so its override bit never takes effect
	property p_port0; companion_owns_port[0] == routing_to_companion[0]; endproperty
	a_port0: assert property (p_port0) else $error("port 0 overridden");
	property p_ovr; clk_en && cfg_wr && cfg_addr == 8'h64 && cfg_be[0] |=>
		companion_owns_port[5:1] == ($past(cfg_wdata[5:1]) | routing_to_companion[5:1]); endproperty
	a_ovr: assert property (p_ovr) else $error("override write");
	property p_cap; clk_en && cfg_rd && cfg_addr == 8'h68 |=> cfg_rdata[15:0] == 16'h0001
		&& cfg_rdata[31:25] == 7'h00 && cfg_rdata[23:17] == 7'h00
		&& cfg_rdata[16] == $past(fw_owned); endproperty
	a_cap: assert property (p_cap) else $error("capability read");
	property p_os; os_owned |-> !fw_owned; endproperty
	a_os: assert property (p_os) else $error("os owned with firmware");
	property p_cs; clk_en && cfg_rd && cfg_addr == 8'h6C |=> cfg_rdata[28:22] == 7'h00; endproperty
	a_cs: assert property (p_cs) else $error("reserved status bits");
endmodule // elpo_regs_monitor

bind elpo_regs elpo_regs_monitor #(.NUM_PORTS(NUM_PORTS)) u_mon (.core_clk(core_clk), .rst(rst),
	.clk_en(clk_en), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
	.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .routing_to_companion(routing_to_companion),
	.enh_connect_raw(enh_connect_raw), .companion_owns_port(companion_owns_port),
	.enh_connect_status(enh_connect_status), .os_owned(os_owned), .fw_owned(fw_owned));

// *** tb/elpo_regs_test.sv ***
/* Self-checking bench for elpo_regs.
   Assumes the checker is bound by its own file. */
module elpo_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Stimulus and helpers
	// ----------------------------------------
	logic core_clk = 0, rst = 1, clk_en = 1, cfg_wr = 0, cfg_rd = 0, os_owned, fw_owned;
	logic [7:0] cfg_addr = 8'h00;
	logic [3:0] cfg_be = 4'h0;
	logic [4:0] sts = 5'h00;
	logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
	logic [5:0] route = 6'h01, raw = 6'h3F, own, conn;
	int bad_count = 0, compares = 0;
	always #12.5 core_clk = ~core_clk;
	elpo_regs dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .sts_async_advance(sts[4]), .sts_host_sys_err(sts[3]),
		.sts_frame_rollover(sts[2]), .sts_port_change(sts[1]),
		.transfer_error_irq_status(sts[0]), .routing_to_companion(route),
		.enh_connect_raw(raw), .companion_owns_port(own), .enh_connect_status(conn),
		.os_owned(os_owned), .fw_owned(fw_owned));
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		@(posedge core_clk);
		{cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, a, b, d};
		@(posedge core_clk);
		cfg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		{cfg_rd, cfg_addr} <= {1'b1, a};
		@(posedge core_clk);
		cfg_rd <= 1'b0;
		#1;
		chk(cfg_rdata, e);
	endtask
	task tally_and_finish;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		rd(8'h64, 32'h0);
		rd(8'h68, 32'h1);
		rd(8'h6C, 32'h0);
		// Port 0 bit stays clear; reserved upper bits are set to prove they drop
		wr(8'h64, 4'hF, 32'hFFFFFFFE);
		rd(8'h64, 32'h3E);
		chk({20'h0, own, conn}, {20'h0, 6'h3F, 6'h01});
		wr(8'h64, 4'hE, 32'h0);
		rd(8'h64, 32'h3E);
		wr(8'h64, 4'h1, 32'h0);
		chk({20'h0, own, conn}, {20'h0, 6'h01, 6'h3F});
		$display("override test done");
		wr(8'h68, 4'hC, 32'h01010000);
		chk({30'h0, os_owned, fw_owned}, 32'h1);
		rd(8'h68, 32'h01010001);
		wr(8'h68, 4'h4, 32'h0);
		chk({30'h0, os_owned, fw_owned}, 32'h2);
		$display("semaphore test done");
		wr(8'h04, 4'h1, 32'h0);
		wr(8'h10, 4'hF, 32'h0);
		@(posedge core_clk) sts <= 5'h1F;
		rd(8'h6C, 32'hE03E0000);
		wr(8'h6C, 4'h8, 32'hFFFFFFFF);
		rd(8'h6C, 32'h003E0000);
		@(posedge core_clk) sts <= 5'h00;
		rd(8'h6C, 32'h0);
		// OS semaphore falling also raises the change flag
		wr(8'h68, 4'h8, 32'h0);
		rd(8'h6C, 32'h20000000);
		chk({30'h0, os_owned, fw_owned}, 32'h0);
		rd(8'h20, 32'h0);
		$display("status test done");
		wr(8'h64, 4'h1, 32'h0000003E);
		wr(8'h68, 4'hC, 32'h01010000);
		@(posedge core_clk) rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd(8'h64, 32'h0);
		rd(8'h68, 32'h1);
		rd(8'h6C, 32'h0);
		$display("reset test done");
		@(posedge core_clk) clk_en <= 1'b0;
		wr(8'h64, 4'h1, 32'h0000003E);
		@(posedge core_clk) clk_en <= 1'b1;
		rd(8'h64, 32'h0);
		$display("clock enable test done");
		tally_and_finish();
	end
	initial begin
		#10000;
		bad_count++;
		tally_and_finish();
	end
endmodule // elpo_regs_test
